// >>> common/imacu_pkg.sv
// Package for the integer multiply-accumulate unit: op codes, carriers, field widths.
// Assumes a 32-bit register file with 16 registers and a condition checker outside.
package imacu_pkg;

  localparam int unsigned IMACU_DATA_W     = 32;
  localparam int unsigned IMACU_REG_IDX_W  = 4;
  localparam int unsigned IMACU_LOW_REG_W  = 3;
  localparam logic [3:0]  IMACU_STACK_IDX  = 4'hd;
  localparam logic [3:0]  IMACU_PROG_IDX   = 4'hf;
  localparam logic [31:0] IMACU_WORD_RESET = 32'h0000_0000;
  localparam logic [3:0]  IMACU_IDX_RESET  = 4'h0;

  typedef enum logic [2:0] {
    IMACU_OP_MULTIPLY_LOW                    = 3'b000,
    IMACU_OP_MULTIPLY_ADD_LOW                = 3'b001,
    IMACU_OP_MULTIPLY_SUBTRACT_LOW           = 3'b010,
    IMACU_OP_UNSIGNED_LONG_PRODUCT           = 3'b011,
    IMACU_OP_UNSIGNED_LONG_DOUBLE_ACCUMULATE = 3'b100,
    IMACU_OP_UNSIGNED_LONG_ACCUMULATE        = 3'b101
  } imacu_op_t;

  // Request from the decoder with operand values already read
  typedef struct packed {
    imacu_op_t   op;
    logic        set_flags;
    logic        cond_pass;
    logic        has_dest;
    logic [3:0]  dest_idx;
    logic [3:0]  high_idx;
    logic [3:0]  first_source_idx;
    logic [31:0] first_source_reg;
    logic [31:0] second_source_reg;
    logic [31:0] accumulator_reg;
    logic [31:0] low_destination;
    logic [31:0] high_destination;
  } imacu_req_t;

  // Write-back to register file and flags
  typedef struct packed {
    logic        wr_low;
    logic [3:0]  low_idx;
    logic [31:0] low_data;
    logic        wr_high;
    logic [3:0]  high_idx;
    logic [31:0] high_data;
    logic        wr_nz;
    logic        flag_n;
    logic        flag_z;
  } imacu_wb_t;

endpackage : imacu_pkg

// >>> rtl/imacu_mult.sv
// Unsigned 32x32 to 64 product, registered.
// Assumes operands arrive with a valid pulse on the same clock.
`timescale 1ns/100ps
module imacu_mult
  import imacu_pkg::*;
#(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Operands
  input  wire logic [W-1:0]     a_in,
  input  wire logic [W-1:0]     b_in,
  // Product
  output logic      [2*W-1:0]   prod_out
);

  logic [2*W-1:0] prod_ff;
  logic [2*W-1:0] nxt_prod;

  always_comb begin
    nxt_prod = a_in * b_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prod_ff <= '0;
    end else begin
      prod_ff <= nxt_prod;
    end
  end

  assign prod_out = prod_ff;

endmodule : imacu_mult

// >>> rtl/imacu_acc.sv
// Adds up to two addends to a 64-bit product, or subtracts it from one.
// Assumes product and addends are stable for the same cycle.
`timescale 1ns/100ps
module imacu_acc
  import imacu_pkg::*;
(
  // Inputs
  input  wire logic [63:0] prod_in,
  input  wire logic [63:0] add_a_in,
  input  wire logic [63:0] add_b_in,
  input  wire logic        subtract_in,
  // Result
  output logic      [63:0] sum_out
);

  always_comb begin
    if (subtract_in) begin
      sum_out = add_a_in - prod_in;
    end else begin
      sum_out = prod_in + add_a_in + add_b_in;
    end
  end

endmodule : imacu_acc

// >>> rtl/imacu_top.sv
// Contract
// (RULE_01) Plain multiply writes the low 32 bits of the product of the two sources.
// (RULE_02) Multiply-add writes the low 32 bits of accumulator plus product.
// (RULE_03) Multiply-subtract writes the low 32 bits of accumulator minus product.
// (RULE_04) The 32-bit result ops use one truncated product valid for signed or unsigned data.
// (RULE_05) Plain multiply without a destination writes back to the first source register.
// (RULE_06) Flag-setting plain multiply sets N and Z from the 32-bit result.
// (RULE_07) Flag-setting plain multiply leaves C and V unchanged.
// (RULE_08) Software keeps flag-setting multiply on R0-R7, destination equal second source, no cond.
// (RULE_09) Software never names stack pointer or program counter in 32-bit result ops.
// (RULE_10) Long product writes low half to low destination, high half to high destination.
// (RULE_11) Double-accumulate adds prior high and low destination words to the 64-bit product.
// (RULE_12) Long accumulate adds the product to the 64-bit destination pair.
// (RULE_13) Software names distinct high and low destinations, never stack pointer or counter.
// (RULE_14) Long multiplies leave all flags unchanged.
// (RULE_15) Every op except the flag-setting form is gated by an optional condition.
// (RULE_16) A failed condition leaves destinations and flags unchanged.
//
// Integer multiply-accumulate unit: one request per cycle, answer two cycles later.
// Assumes the decoder has evaluated the condition and read all operand registers.
`timescale 1ns/100ps
module imacu_top
  import imacu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Request
  input  wire logic        req_valid_in,
  input  wire imacu_req_t  req_in,
  // Write-back
  output logic             wb_valid_out,
  output imacu_wb_t        wb_out
);

  // Stage 1 state: request held while the product forms
  logic       s1_valid_ff;
  logic       nxt_s1_valid;
  imacu_req_t s1_req_ff;
  imacu_req_t nxt_s1_req;
  // Stage 2 state: registered write-back
  logic       wb_valid_ff;
  logic       nxt_wb_valid;
  imacu_wb_t  wb_ff;
  imacu_wb_t  nxt_wb;
  // Datapath nets
  logic [63:0] prod;
  logic [63:0] acc_sum;
  logic [63:0] add_a;
  logic [63:0] add_b;
  logic        do_sub;
  logic        effective;

  // Unsigned product; low half is sign-agnostic
  imacu_mult #(.W(IMACU_DATA_W)) u_mult ( // RULE_04
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .a_in      (req_in.first_source_reg),
    .b_in      (req_in.second_source_reg),
    .prod_out  (prod)
  );

  imacu_acc u_acc (
    .prod_in     (prod),
    .add_a_in    (add_a),
    .add_b_in    (add_b),
    .subtract_in (do_sub),
    .sum_out     (acc_sum)
  );

  always_comb begin
    nxt_s1_valid = req_valid_in;
    nxt_s1_req   = req_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_valid_ff <= 1'b0;
      s1_req_ff   <= '0;
    end else begin
      s1_valid_ff <= nxt_s1_valid;
      s1_req_ff   <= nxt_s1_req;
    end
  end

  // Addend selection per op
  always_comb begin
    add_a  = '0;
    add_b  = '0;
    do_sub = 1'b0;
    case (s1_req_ff.op)
      IMACU_OP_MULTIPLY_ADD_LOW: begin
        add_a = {32'h0000_0000, s1_req_ff.accumulator_reg}; // RULE_02
      end
      IMACU_OP_MULTIPLY_SUBTRACT_LOW: begin
        add_a  = {32'h0000_0000, s1_req_ff.accumulator_reg}; // RULE_03
        do_sub = 1'b1; // RULE_03
      end
      IMACU_OP_UNSIGNED_LONG_DOUBLE_ACCUMULATE: begin
        add_a = {32'h0000_0000, s1_req_ff.high_destination}; // RULE_11
        add_b = {32'h0000_0000, s1_req_ff.low_destination}; // RULE_11
      end
      IMACU_OP_UNSIGNED_LONG_ACCUMULATE: begin
        add_a = {s1_req_ff.high_destination, s1_req_ff.low_destination}; // RULE_12
      end
      default: begin
        add_a = '0;
      end
    endcase
  end

  // Flag form ignores the condition; others obey it
  assign effective = s1_valid_ff &&
                     ((s1_req_ff.op == IMACU_OP_MULTIPLY_LOW && s1_req_ff.set_flags) ||
                      s1_req_ff.cond_pass); // RULE_15 RULE_16

  always_comb begin
    nxt_wb_valid     = effective;
    nxt_wb           = '0;
    nxt_wb.low_data  = acc_sum[31:0]; // RULE_01 RULE_02 RULE_03 RULE_10
    nxt_wb.high_data = acc_sum[63:32]; // RULE_10 RULE_11 RULE_12
    nxt_wb.low_idx   = s1_req_ff.dest_idx;
    nxt_wb.high_idx  = s1_req_ff.high_idx;
    case (s1_req_ff.op)
      IMACU_OP_MULTIPLY_LOW: begin
        nxt_wb.wr_low = effective;
        if (!s1_req_ff.has_dest) begin
          nxt_wb.low_idx = s1_req_ff.first_source_idx; // RULE_05
        end
        nxt_wb.wr_nz  = effective && s1_req_ff.set_flags; // RULE_06 RULE_07
        nxt_wb.flag_n = acc_sum[31]; // RULE_06
        nxt_wb.flag_z = (acc_sum[31:0] == 32'h0000_0000); // RULE_06
      end
      IMACU_OP_MULTIPLY_ADD_LOW,
      IMACU_OP_MULTIPLY_SUBTRACT_LOW: begin
        nxt_wb.wr_low = effective;
      end
      IMACU_OP_UNSIGNED_LONG_PRODUCT,
      IMACU_OP_UNSIGNED_LONG_DOUBLE_ACCUMULATE,
      IMACU_OP_UNSIGNED_LONG_ACCUMULATE: begin
        nxt_wb.wr_low  = effective; // RULE_14
        nxt_wb.wr_high = effective;
      end
      default: begin
        nxt_wb.wr_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_valid_ff <= 1'b0;
      wb_ff       <= '0;
    end else begin
      wb_valid_ff <= nxt_wb_valid;
      wb_ff       <= nxt_wb;
    end
  end

  assign wb_valid_out = wb_valid_ff;
  assign wb_out       = wb_ff;

  // Assertion helpers: request history
  imacu_req_t r1_ff;
  imacu_req_t r2_ff;
  logic       v1_ff;
  logic       v2_ff;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r1_ff <= '0;
      r2_ff <= '0;
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
    end else begin
      r1_ff <= req_in;
      r2_ff <= r1_ff;
      v1_ff <= req_valid_in;
      v2_ff <= v1_ff;
    end
  end

  // Reference low product of the request two cycles back
  logic [31:0] r2_low_prod;
  assign r2_low_prod = 32'(r2_ff.first_source_reg * r2_ff.second_source_reg);

  // Result values, flag writes, implicit destination index and condition gating
  a_low_product: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_01
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_MULTIPLY_LOW |->
    wb_out.wr_low && wb_out.low_data ==
    32'(r2_ff.first_source_reg * r2_ff.second_source_reg))
    else $error("multiply low result wrong");

  a_add_result: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_02
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_MULTIPLY_ADD_LOW |->
    wb_out.low_data == 32'(r2_ff.accumulator_reg +
    r2_ff.first_source_reg * r2_ff.second_source_reg))
    else $error("multiply add result wrong");

  a_sub_result: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_03
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_MULTIPLY_SUBTRACT_LOW |->
    wb_out.low_data == 32'(r2_ff.accumulator_reg -
    r2_ff.first_source_reg * r2_ff.second_source_reg))
    else $error("multiply subtract result wrong");

  a_signed_same: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_04
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_MULTIPLY_LOW |->
    wb_out.low_data == 32'($signed(r2_ff.first_source_reg) *
    $signed(r2_ff.second_source_reg)))
    else $error("signed low product differs");

  a_no_dest_idx: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_05
    v2_ff && r2_ff.op == IMACU_OP_MULTIPLY_LOW && !r2_ff.has_dest |->
    wb_out.low_idx == r2_ff.first_source_idx)
    else $error("implicit destination wrong");

  a_nz_flags: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_06
    v2_ff && r2_ff.op == IMACU_OP_MULTIPLY_LOW && r2_ff.set_flags |->
    wb_out.wr_nz && wb_out.flag_n == r2_low_prod[31] &&
    wb_out.flag_z == (r2_low_prod == 32'h0000_0000))
    else $error("N or Z flag wrong");

  a_long_value: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_10
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_UNSIGNED_LONG_PRODUCT |->
    {wb_out.high_data, wb_out.low_data} ==
    64'(r2_ff.first_source_reg) * 64'(r2_ff.second_source_reg))
    else $error("long product wrong");

  a_double_acc: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_11
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_UNSIGNED_LONG_DOUBLE_ACCUMULATE |->
    {wb_out.high_data, wb_out.low_data} == 64'(r2_ff.first_source_reg) *
    64'(r2_ff.second_source_reg) + 64'(r2_ff.high_destination) +
    64'(r2_ff.low_destination))
    else $error("double accumulate wrong");

  a_long_acc: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_12
    v2_ff && r2_ff.cond_pass && r2_ff.op == IMACU_OP_UNSIGNED_LONG_ACCUMULATE |->
    {wb_out.high_data, wb_out.low_data} == 64'(r2_ff.first_source_reg) *
    64'(r2_ff.second_source_reg) + {r2_ff.high_destination, r2_ff.low_destination})
    else $error("long accumulate wrong");

  a_long_noflag: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_14
    v2_ff && r2_ff.op != IMACU_OP_MULTIPLY_LOW |-> !wb_out.wr_nz)
    else $error("long op touched flags");

  a_flag_only_s: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_07
    wb_out.wr_nz |-> $past(s1_req_ff.set_flags))
    else $error("flags written without S form");

  a_cond_fail: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_16
    v2_ff && !r2_ff.cond_pass && !(r2_ff.op == IMACU_OP_MULTIPLY_LOW && r2_ff.set_flags) |->
    !wb_valid_out && !wb_out.wr_low && !wb_out.wr_high && !wb_out.wr_nz)
    else $error("failed condition wrote state");

  a_cond_pass: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_15
    req_valid_in && req_in.cond_pass |-> ##2 wb_valid_out)
    else $error("passed request gave no answer");

  // Write enables and indices
  a_flag_form_runs: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_15
    v2_ff && r2_ff.op == IMACU_OP_MULTIPLY_LOW && r2_ff.set_flags |->
    wb_valid_out && wb_out.wr_low)
    else $error("flag form did not execute");

  a_pass_low_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_15
    v2_ff && r2_ff.cond_pass && r2_ff.op <= IMACU_OP_UNSIGNED_LONG_ACCUMULATE |->
    wb_out.wr_low)
    else $error("passed op wrote no register");

  a_answer_has_req: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_15
    wb_valid_out |-> $past(s1_valid_ff))
    else $error("answer without a held request");

  a_low_dest_idx: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_10
    v2_ff && (r2_ff.has_dest || r2_ff.op != IMACU_OP_MULTIPLY_LOW) |->
    wb_out.low_idx == r2_ff.dest_idx)
    else $error("low destination index wrong");

  a_high_dest_idx: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_10
    v2_ff && r2_ff.op >= IMACU_OP_UNSIGNED_LONG_PRODUCT |->
    wb_out.high_idx == r2_ff.high_idx)
    else $error("high destination index wrong");

  a_no_high_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_01
    v2_ff && r2_ff.op <= IMACU_OP_MULTIPLY_SUBTRACT_LOW |-> !wb_out.wr_high)
    else $error("32-bit op wrote high register");

  a_pair_written: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_12
    v2_ff && r2_ff.cond_pass && r2_ff.op >= IMACU_OP_UNSIGNED_LONG_PRODUCT &&
    r2_ff.op <= IMACU_OP_UNSIGNED_LONG_ACCUMULATE |-> wb_out.wr_low && wb_out.wr_high)
    else $error("long op missed a destination");

  a_plain_no_flags: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_06
    v2_ff && r2_ff.op == IMACU_OP_MULTIPLY_LOW && !r2_ff.set_flags |-> !wb_out.wr_nz)
    else $error("plain multiply wrote flags");

  a_flag_op_only: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_07
    wb_out.wr_nz |-> v2_ff && r2_ff.op == IMACU_OP_MULTIPLY_LOW)
    else $error("flags written by wrong op");

  a_write_valid: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_16
    wb_out.wr_low || wb_out.wr_high || wb_out.wr_nz |-> wb_valid_out)
    else $error("write enable without answer");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_16
    !v2_ff |-> !wb_valid_out)
    else $error("answer without a request");

  // Scenario covers
  c_flag_form: cover property (@(posedge clk_in) disable iff (!resetn_in) wb_out.wr_nz);
  c_flag_cond_fail: cover property (@(posedge clk_in) disable iff (!resetn_in)
    v2_ff && !r2_ff.cond_pass && wb_out.wr_nz);
  c_long: cover property (@(posedge clk_in) disable iff (!resetn_in) wb_out.wr_high);
  c_skip: cover property (@(posedge clk_in) disable iff (!resetn_in)
    v2_ff && !wb_valid_out);
  c_b2b: cover property (@(posedge clk_in) disable iff (!resetn_in)
    wb_valid_out [*3]);

endmodule : imacu_top

// >>> tb/imacu_rf_model.sv
// Register file and flag model that takes the unit's write-back.
// Assumes the bench reads operand values from regs_out.
`timescale 1ns/100ps
module imacu_rf_model
  import imacu_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      resetn_in,
  // Write-back
  input  wire logic      wb_valid_in,
  input  wire imacu_wb_t wb_in,
  // State
  output logic [31:0]    regs_out [16],
  output logic [3:0]     nzcv_out
);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 16; i++) begin
        regs_out[i] <= (32'(i) * 32'h9e37_79b9) ^ {4'(i), 28'h000_0000};
      end
      nzcv_out <= 4'h3;
    end else if (wb_valid_in) begin
      if (wb_in.wr_low) regs_out[wb_in.low_idx] <= wb_in.low_data;
      if (wb_in.wr_high) regs_out[wb_in.high_idx] <= wb_in.high_data;
      if (wb_in.wr_nz) nzcv_out[3:2] <= {wb_in.flag_n, wb_in.flag_z};
    end
  end
endmodule : imacu_rf_model

// >>> tb/tb.sv
// Self-checking bench for imacu_top with the register file model.
// Assumes a 100 MHz clock and stimulus on the falling edge.
`timescale 1ns/100ps
module tb;
  import imacu_pkg::*;
  logic        clk_in;
  logic        resetn_in;
  logic        req_valid_in;
  imacu_req_t  req_in;
  logic        wb_valid_out;
  imacu_wb_t   wb_out;
  logic [31:0] regs [16];
  logic [3:0]  nzcv;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  imacu_req_t  q [$];

  imacu_top uut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .wb_valid_out(wb_valid_out), .wb_out(wb_out));
  imacu_rf_model rf (.clk_in(clk_in), .resetn_in(resetn_in), .wb_valid_in(wb_valid_out),
    .wb_in(wb_out), .regs_out(regs), .nzcv_out(nzcv));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic imacu_req_t mk(imacu_op_t op, int sf, int cp, int hd, int d, int h,
                                    int n, int m, int a);
    mk = '{op:op, set_flags:1'(sf), cond_pass:1'(cp), has_dest:1'(hd), dest_idx:4'(d),
           high_idx:4'(h), first_source_idx:4'(n), first_source_reg:regs[n],
           second_source_reg:regs[m], accumulator_reg:regs[a],
           low_destination:regs[d], high_destination:regs[h]};
  endfunction : mk

  function automatic logic [63:0] exp64(imacu_req_t r);
    logic [63:0] p;
    p = {32'h0000_0000, r.first_source_reg} * {32'h0000_0000, r.second_source_reg};
    case (r.op)
      IMACU_OP_MULTIPLY_LOW: exp64 = {32'h0000_0000,
        $signed(r.first_source_reg) * $signed(r.second_source_reg)};
      IMACU_OP_MULTIPLY_ADD_LOW: exp64 = {32'h0000_0000, r.accumulator_reg + p[31:0]};
      IMACU_OP_MULTIPLY_SUBTRACT_LOW: exp64 = {32'h0000_0000, r.accumulator_reg - p[31:0]};
      IMACU_OP_UNSIGNED_LONG_PRODUCT: exp64 = p;
      IMACU_OP_UNSIGNED_LONG_DOUBLE_ACCUMULATE: exp64 = p + {32'h0000_0000, r.high_destination}
        + {32'h0000_0000, r.low_destination};
      default: exp64 = p + {r.high_destination, r.low_destination};
    endcase
  endfunction : exp64

  task automatic chk(input imacu_req_t r);
    logic [63:0] e;
    logic        lng;
    logic        fl;
    logic        ev;
    e   = exp64(r);
    lng = (r.op >= IMACU_OP_UNSIGNED_LONG_PRODUCT);
    fl  = (r.op == IMACU_OP_MULTIPLY_LOW) && r.set_flags;
    ev  = r.cond_pass | fl;
    check("wb_valid", wb_valid_out, ev);
    check("wr_low", wb_out.wr_low, ev);
    check("wr_high", wb_out.wr_high, ev & lng);
    check("wr_nz", wb_out.wr_nz, ev & fl);
    if (ev) begin
      check("low_idx", wb_out.low_idx, r.has_dest ? r.dest_idx : r.first_source_idx);
      check("low_data", wb_out.low_data, e[31:0]);
      if (lng) check("high", {wb_out.high_idx, wb_out.high_data}, {r.high_idx, e[63:32]});
      if (fl) check("nz", {wb_out.flag_n, wb_out.flag_z}, {e[31], e[31:0] == 32'h0000_0000});
    end
  endtask : chk

  task automatic run();
    for (int t = 0; t < q.size() + 2; t++) begin
      @(negedge clk_in);
      if (t >= 2) chk(q[t - 2]);
      req_valid_in = (t < q.size());
      if (t < q.size()) req_in = q[t];
    end
    @(negedge clk_in);
    q.delete();
  endtask : run

  task automatic t_low();
    q.push_back(mk(IMACU_OP_MULTIPLY_LOW, 0, 1, 1, 5, 0, 1, 2, 0));
    q.push_back(mk(IMACU_OP_MULTIPLY_LOW, 0, 1, 0, 0, 0, 3, 4, 0));
    q.push_back(mk(IMACU_OP_MULTIPLY_ADD_LOW, 0, 1, 1, 6, 0, 12, 14, 7));
    q.push_back(mk(IMACU_OP_MULTIPLY_SUBTRACT_LOW, 0, 1, 1, 7, 0, 11, 12, 0));
    run();
    $display("test low ops done");
  endtask : t_low

  task automatic t_flags();
    imacu_req_t  r;
    logic [63:0] e;
    for (int k = 0; k < 3; k++) begin
      r = mk(IMACU_OP_MULTIPLY_LOW, 1, k % 2, 1, 2 * k + 1, 0, 2 * k, 2 * k + 1, 0);
      e = exp64(r);
      q.push_back(r);
      run();
      check("flags", nzcv, {e[31], e[31:0] == 32'h0000_0000, 2'b11});
    end
    $display("test flags done");
  endtask : t_flags

  task automatic t_b2b();
    int         dt [6] = '{5, 6, 7, 8, 10, 12};
    int         ht [6] = '{0, 0, 0, 9, 11, 14};
    logic [3:0] f;
    f = nzcv;
    for (int k = 0; k < 12; k++) begin
      q.push_back(mk(imacu_op_t'(k / 2), 0, k % 2, 1, dt[k / 2], ht[k / 2],
                     k % 4 + 1, 4 - k % 4, 3));
    end
    run();
    check("flags kept", nzcv, f);
    $display("test back to back done");
  endtask : t_b2b

  task automatic t_reset();
    req_valid_in = 1'b1;
    req_in       = mk(IMACU_OP_MULTIPLY_LOW, 0, 1, 1, 5, 0, 1, 2, 0);
    @(negedge clk_in);
    resetn_in    = 1'b0;
    req_valid_in = 1'b0;
    @(negedge clk_in);
    check("reset valid", wb_valid_out, 1'h0);
    check("reset writes", {wb_out.wr_low, wb_out.wr_high, wb_out.wr_nz}, 3'h0);
    resetn_in = 1'b1;
    @(negedge clk_in);
    check("after reset valid", wb_valid_out, 1'h0);
    $display("test reset done");
  endtask : t_reset

  initial begin
    resetn_in    = 1'b0;
    req_valid_in = 1'b0;
    req_in       = '0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    t_low();
    t_flags();
    t_b2b();
    t_reset();
    print_verdict();
  end
endmodule : tb
